//--- rtl/cipl_pkg.sv
/*
 Constants, timing figures and pin carrier for the tape input controller.
 Assumes a 125 MHz core clock and a single cassette port on the low address byte.
*/
package cipl_pkg;
   // ==========================================================
   // Port map
   localparam logic [7:0] PORT_ADDR = 8'hff;
   localparam int MOTOR_BIT = 2;
   localparam int LATCH_BIT = 0;
   localparam logic [7:0] DATA_IDLE = 8'h00;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int STROBE_NS = 500;
   localparam int BIT_TIME_US = 2000;
   localparam int CLEAR_AT_US = 250;
   localparam int READ_AT_US = 1500;
   localparam int NS_PER_US = 1000;
   // Least times round up
   localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CLEAR_AT_CYC = (CLEAR_AT_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READ_AT_CYC = (READ_AT_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BIT_TIME_CYC = (BIT_TIME_US * NS_PER_US) / CLK_PERIOD_NS;
   localparam int STROBE_W = 8;
   localparam int CNT_W = 20;
   localparam int WORD_W = 8;

   // ==========================================================
   // Pin carrier
   typedef struct packed {
      logic [7:0] addr;
      logic rd_n;
      logic wr_n;
      logic [7:0] dout;
      logic oe;
   } cipl_pin_s;

   typedef enum {CYC_IDLE, CYC_SETUP, CYC_STROBE, CYC_HOLD} cipl_cyc_e;
   typedef enum {ST_IDLE, ST_INIT_WR, ST_POLL_RD, ST_WAIT_CLR, ST_CLR_WR, ST_WAIT_RD, ST_SAMPLE_RD,
                 ST_EXTRA_WR, ST_STOP_WR} cipl_state_e;
endpackage

//--- rtl/cipl_port_cycle.sv
/*
 One port access on the processor side: address setup, a timed low strobe, hold.
 Assumes the device decodes the low address byte and answers reads during the strobe.
*/
module cipl_port_cycle
   import cipl_pkg::*;
#(
   parameter int STROBE_LEN = STROBE_CYC
)
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_go,
   input wire logic i_write,
   input wire logic [7:0] i_wdata,
   input wire logic [7:0] i_data,
   output cipl_pkg::cipl_pin_s o_pins,
   output logic o_busy,
   output logic o_done,
   output logic [7:0] o_rdata
);
   import cipl_pkg::*;

   cipl_cyc_e state_q, state_d;
   logic [STROBE_W-1:0] cnt_q;
   logic write_q;
   cipl_pin_s pins_q;
   logic [7:0] rdata_q;
   logic done_q;

   // ==========================================================
   // Sequencing
   wire strobe_last = (cnt_q == STROBE_W'(STROBE_LEN - 1));
   assign o_busy = (state_q != CYC_IDLE);

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         CYC_IDLE: if (i_go) state_d = CYC_SETUP;
         CYC_SETUP: state_d = CYC_STROBE;
         CYC_STROBE: if (strobe_last) state_d = CYC_HOLD;
         CYC_HOLD: state_d = CYC_IDLE;
         default: state_d = CYC_IDLE;
      endcase
   end

   // Pins come from flops so the strobes never glitch
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         state_q <= CYC_IDLE;
         cnt_q <= '0;
         write_q <= 1'b0;
         pins_q <= '{addr: 8'h00, rd_n: 1'b1, wr_n: 1'b1, dout: DATA_IDLE, oe: 1'b0};
         rdata_q <= 8'h00;
         done_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         done_q <= (state_q == CYC_HOLD);
         cnt_q <= (state_q == CYC_STROBE) ? cnt_q + 1'b1 : '0;
         if (state_q == CYC_IDLE && i_go)
         begin
            write_q <= i_write;
            pins_q.addr <= PORT_ADDR;
            pins_q.dout <= i_wdata;
            pins_q.oe <= i_write;
         end
         // Strobe only between setup and hold
         pins_q.rd_n <= !(state_d == CYC_STROBE && !write_q);
         pins_q.wr_n <= !(state_d == CYC_STROBE && write_q);
         if (state_q == CYC_STROBE && strobe_last && !write_q)
            rdata_q <= i_data; // Sampled while the buffer still drives
         if (state_q == CYC_HOLD)
            pins_q.oe <= 1'b0;
      end
   end

   assign o_pins = pins_q;
   assign o_rdata = rdata_q;
   assign o_done = done_q;
endmodule

//--- rtl/cipl_host.sv
/*
 Processor-side controller for the cassette pulse latch: starts a tape load,
 times each bit from its start pulse, clears and reads the latch, and packs bits
 into words. Assumes the latch device on the far side of the port pins.
*/
// Behaviour
// - At load start a port write turns the motor on and clears the latch.
// - The first detected pulse starts bit one and each later start pulse starts the next bit.
// - A latch found high at the read means a second pulse came, so the bit is one.
// - After a one, an extra write clears the latch before the next bit starts.
// - Bit times are two milliseconds, with a mid-bit pulse only for a one.
// - The clear-and-read cycle repeats for every bit and bits are packed into words.
module cipl_host
   import cipl_pkg::*;
#(
   parameter int CLEAR_AT = CLEAR_AT_CYC,
   parameter int READ_AT = READ_AT_CYC,
   parameter int STROBE_LEN = STROBE_CYC
)
(
   input wire logic I_CORE_CLK,
   input wire logic I_ARST_N,
   input wire logic I_LOAD_START,
   input wire logic I_LOAD_STOP,
   input wire logic [7:0] I_DATA,
   output cipl_pkg::cipl_pin_s O_PORT,
   output logic O_MOTOR_ON,
   output logic O_BUSY,
   output logic O_BIT_VALID,
   output logic O_BIT,
   output logic O_WORD_VALID,
   output logic [WORD_W-1:0] O_WORD
);
   import cipl_pkg::*;

   // ==========================================================
   // Reset release
   logic rst_meta_q, rst_sync_n_q;

   always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
   begin
      if (!I_ARST_N)
      begin
         rst_meta_q <= 1'b0;
         rst_sync_n_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_sync_n_q <= rst_meta_q;
      end
   end

   // ==========================================================
   // Port access engine
   cipl_state_e state_q, state_d;
   logic pend_q, stop_q, motor_q;
   logic [CNT_W-1:0] cnt_q;
   logic bit_valid_q, bit_q, word_valid_q;
   logic [WORD_W-1:0] shift_q, word_q;
   logic [$clog2(WORD_W)-1:0] nbit_q;
   logic cyc_busy, cyc_done;
   logic [7:0] cyc_rdata;

   wire access_st = (state_q == ST_INIT_WR) || (state_q == ST_POLL_RD) || (state_q == ST_CLR_WR) ||
                    (state_q == ST_SAMPLE_RD) || (state_q == ST_EXTRA_WR) || (state_q == ST_STOP_WR);
   wire is_write = (state_q != ST_POLL_RD) && (state_q != ST_SAMPLE_RD);
   wire go = access_st && !pend_q && !cyc_busy;
   wire motor_next = (state_q != ST_STOP_WR);
   // Every write but the stop write keeps the motor bit, so a clearing write never stops the tape
   wire [7:0] wdata = 8'(motor_next) << MOTOR_BIT;
   wire latch_hi = cyc_rdata[LATCH_BIT];
   wire acc_done = pend_q && cyc_done;
   wire reach_clr = (cnt_q >= CNT_W'(CLEAR_AT));
   wire reach_rd = (cnt_q >= CNT_W'(READ_AT));

   cipl_port_cycle #(.STROBE_LEN(STROBE_LEN)) u_cycle (
      .i_clk(I_CORE_CLK),
      .i_rst_n(rst_sync_n_q),
      .i_go(go),
      .i_write(is_write),
      .i_wdata(wdata),
      .i_data(I_DATA),
      .o_pins(O_PORT),
      .o_busy(cyc_busy),
      .o_done(cyc_done),
      .o_rdata(cyc_rdata)
   );

   // ==========================================================
   // Bit timing sequence
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: if (I_LOAD_START) state_d = ST_INIT_WR;
         ST_INIT_WR: if (acc_done) state_d = ST_POLL_RD; // Motor on, latch cleared
         ST_POLL_RD:
            if (acc_done)
            begin
               if (stop_q)
                  state_d = ST_STOP_WR;
               else if (latch_hi)
                  state_d = ST_WAIT_CLR; // Start pulse opens a bit time
            end
         ST_WAIT_CLR: if (reach_clr) state_d = ST_CLR_WR;
         ST_CLR_WR: if (acc_done) state_d = ST_WAIT_RD;
         ST_WAIT_RD: if (reach_rd) state_d = ST_SAMPLE_RD; // Read after the mid-bit slot
         ST_SAMPLE_RD:
            if (acc_done)
               state_d = latch_hi ? ST_EXTRA_WR : ST_POLL_RD;
         ST_EXTRA_WR: if (acc_done) state_d = ST_POLL_RD;
         ST_STOP_WR: if (acc_done) state_d = ST_IDLE;
         default: state_d = ST_IDLE;
      endcase
   end

   // ==========================================================
   // Access bookkeeping
   // An access stays pending from its launch until its done pulse
   wire pend_d = go ? 1'b1 : (cyc_done ? 1'b0 : pend_q);
   // A stop request wins over the idle clear, so it is never lost in the same cycle
   wire stop_d = I_LOAD_STOP ? 1'b1 : ((state_q == ST_IDLE) ? 1'b0 : stop_q);
   // Motor follows the bit that each completed write carried
   wire motor_d = (acc_done && is_write) ? motor_next : motor_q;
   // Bit timer restarts at each start pulse and saturates, so a dead tape never wraps it
   wire bit_start = (state_q == ST_POLL_RD) && (state_d == ST_WAIT_CLR);
   wire cnt_max = (cnt_q == {CNT_W{1'b1}});
   wire [CNT_W-1:0] cnt_d = bit_start ? '0 : (cnt_max ? cnt_q : cnt_q + 1'b1);

   // Sequence state
   always_ff @(posedge I_CORE_CLK or negedge rst_sync_n_q)
   begin
      if (!rst_sync_n_q)
         state_q <= ST_IDLE;
      else
         state_q <= state_d;
   end

   // Pending access and stop request
   always_ff @(posedge I_CORE_CLK or negedge rst_sync_n_q)
   begin
      if (!rst_sync_n_q)
      begin
         pend_q <= 1'b0;
         stop_q <= 1'b0;
      end
      else
      begin
         pend_q <= pend_d;
         stop_q <= stop_d;
      end
   end

   // Motor state as last written
   always_ff @(posedge I_CORE_CLK or negedge rst_sync_n_q)
   begin
      if (!rst_sync_n_q)
         motor_q <= 1'b0;
      else
         motor_q <= motor_d;
   end

   // Bit timer
   always_ff @(posedge I_CORE_CLK or negedge rst_sync_n_q)
   begin
      if (!rst_sync_n_q)
         cnt_q <= '0;
      else
         cnt_q <= cnt_d;
   end

   // ==========================================================
   // Bit and word output
   wire bit_now = (state_q == ST_SAMPLE_RD) && acc_done;
   wire word_full = (nbit_q == ($clog2(WORD_W))'(WORD_W - 1));
   // Bits enter MSB first, so the first bit of a word ends in its top bit
   wire [WORD_W-1:0] shift_d = {shift_q[WORD_W-2:0], latch_hi};

   // One-cycle strobes for a bit and for a completed word
   always_ff @(posedge I_CORE_CLK or negedge rst_sync_n_q)
   begin
      if (!rst_sync_n_q)
      begin
         bit_valid_q <= 1'b0;
         word_valid_q <= 1'b0;
      end
      else
      begin
         bit_valid_q <= bit_now;
         word_valid_q <= bit_now && word_full;
      end
   end

   // Word assembly; a partial word at stop is dropped, not flushed
   always_ff @(posedge I_CORE_CLK or negedge rst_sync_n_q)
   begin
      if (!rst_sync_n_q)
      begin
         bit_q <= 1'b0;
         shift_q <= '0;
         word_q <= '0;
         nbit_q <= '0;
      end
      else
      begin
         if (state_q == ST_INIT_WR)
            nbit_q <= '0;
         if (bit_now)
         begin
            bit_q <= latch_hi; // High means one, low means zero
            shift_q <= shift_d;
            nbit_q <= word_full ? '0 : nbit_q + 1'b1;
            if (word_full)
               word_q <= shift_d;
         end
      end
   end

   assign O_MOTOR_ON = motor_q;
   assign O_BUSY = (state_q != ST_IDLE);
   assign O_BIT_VALID = bit_valid_q;
   assign O_BIT = bit_q;
   assign O_WORD_VALID = word_valid_q;
   assign O_WORD = word_q;
endmodule

//--- dv/cipl_host_sva.sv
/*
 Port checker for the tape input controller.
 Assumes binding to cipl_host and its timing parameters.
*/
module cipl_host_sva
   import cipl_pkg::*;
#(
   parameter int CLEAR_AT = 20,
   parameter int READ_AT = 60,
   parameter int STROBE_LEN = 4
)
(
   input wire logic I_CORE_CLK,
   input wire logic I_ARST_N,
   input wire logic I_LOAD_START,
   input wire logic I_LOAD_STOP,
   input wire logic [7:0] I_DATA,
   input cipl_pkg::cipl_pin_s O_PORT,
   input wire logic O_MOTOR_ON,
   input wire logic O_BUSY,
   input wire logic O_BIT_VALID,
   input wire logic O_BIT,
   input wire logic O_WORD_VALID,
   input wire logic [WORD_W-1:0] O_WORD
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] len_q;
   logic rd_bit_q;
   logic mot_q;
   default clocking @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_ARST_N);
   // ==========
   // Helpers: strobe length, last read bit, last motor value
   always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
   begin
      if (!I_ARST_N)
      begin
         len_q <= 8'h00;
         rd_bit_q <= 1'b0;
         mot_q <= 1'b0;
      end
      else
      begin
         len_q <= (!O_PORT.rd_n || !O_PORT.wr_n) ? len_q + 8'h01 : 8'h00;
         rd_bit_q <= !O_PORT.rd_n ? I_DATA[LATCH_BIT] : rd_bit_q;
         mot_q <= !O_PORT.wr_n ? O_PORT.dout[MOTOR_BIT] : mot_q;
      end
   end
   // ==========
   // Assertions
   a_strobes_exclusive: assert property (O_PORT.rd_n || O_PORT.wr_n) else $error("both strobes low");
   a_port_address: assert property (!(O_PORT.rd_n && O_PORT.wr_n) |-> O_PORT.addr == PORT_ADDR)
      else $error("strobe without port address");
   a_read_floats: assert property (!O_PORT.rd_n |-> !O_PORT.oe) else $error("bus driven on read");
   a_write_drives: assert property (!O_PORT.wr_n |-> O_PORT.oe) else $error("bus idle on write");
   a_strobe_length: assert property ($rose(O_PORT.rd_n) || $rose(O_PORT.wr_n) |-> len_q == STROBE_LEN)
      else $error("strobe length wrong");
   a_load_clears: assert property ($rose(O_BUSY) |-> ##[1:4] !O_PORT.wr_n && O_PORT.dout[MOTOR_BIT])
      else $error("load start without clearing write");
   a_motor_follows: assert property ($rose(O_PORT.wr_n) |-> ##[0:3] O_MOTOR_ON == mot_q)
      else $error("motor state differs from write");
   a_bit_from_read: assert property (O_BIT_VALID |-> O_BIT == rd_bit_q) else $error("bit differs from read");
   a_one_cleared: assert property (O_BIT_VALID && O_BIT |-> ##[1:12] $fell(O_PORT.wr_n))
      else $error("no extra clear after one");
   a_word_on_bit: assert property (O_WORD_VALID |-> O_BIT_VALID && O_WORD[0] == O_BIT)
      else $error("word not on last bit");
   c_one: cover property (O_BIT_VALID && O_BIT);
   c_zero: cover property (O_BIT_VALID && !O_BIT);
   c_word: cover property (O_WORD_VALID);
endmodule

bind cipl_host cipl_host_sva #(.CLEAR_AT(CLEAR_AT), .READ_AT(READ_AT), .STROBE_LEN(STROBE_LEN)) cipl_host_sva_i (
   .I_CORE_CLK(I_CORE_CLK), .I_ARST_N(I_ARST_N), .I_LOAD_START(I_LOAD_START), .I_LOAD_STOP(I_LOAD_STOP),
   .I_DATA(I_DATA), .O_PORT(O_PORT), .O_MOTOR_ON(O_MOTOR_ON), .O_BUSY(O_BUSY), .O_BIT_VALID(O_BIT_VALID),
   .O_BIT(O_BIT), .O_WORD_VALID(O_WORD_VALID), .O_WORD(O_WORD));

//--- dv/cipl_latch_model.sv
/*
 Behavioural tape pulse latch with port decode and read buffer.
 Assumes the host pins struct and an active-low level detector input.
*/
module cipl_latch_model
   import cipl_pkg::*;
(
   input wire logic i_clk,
   input cipl_pkg::cipl_pin_s i_pins,
   input wire logic i_tape_det_n,
   output logic [7:0] o_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic port_match_n;
   logic cassette_read_select_n;
   logic cassette_write_select_n;
   logic latch_q = 1'b0;
   logic float_q = 1'b0;
   // Port decode on the low address byte only
   assign port_match_n = (i_pins.addr != PORT_ADDR);
   assign cassette_read_select_n = i_pins.rd_n | port_match_n;
   assign cassette_write_select_n = i_pins.wr_n | port_match_n;
   // Set wins over clear, as in a cross-coupled gate pair
   always @*
   begin
      if (!i_tape_det_n)
         latch_q = 1'b1;
      else if (!cassette_write_select_n)
         latch_q = 1'b0;
   end
   // Floating bus toggles so a stale value never passes
   always @(posedge i_clk)
      float_q <= ~float_q;
   assign o_data = i_pins.oe ? i_pins.dout
                 : cassette_read_select_n ? {8{float_q}} : {7'h00, latch_q};
endmodule

//--- dv/cipl_host_tb_top.sv
/*
 Self-checking bench: replays tape bytes through the latch model.
 Assumes small timing parameters and the latch model on the port.
*/
module cipl_host_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import cipl_pkg::*;
   localparam int BIT_CYC = 120;
   localparam int MID_CYC = 45;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic load_start = 1'b0;
   logic load_stop = 1'b0;
   logic tape_det_n = 1'b1;
   logic [7:0] data;
   cipl_pin_s port;
   logic motor_on, busy, bit_valid, o_bit, word_valid;
   logic [7:0] word;
   int errors = 0;
   int n_tests = 0;
   int cycles = 0;
   logic bits_q[$];
   logic [7:0] words_q[$];
   cipl_host #(.CLEAR_AT(20), .READ_AT(60), .STROBE_LEN(4)) cipl_host_i (.I_CORE_CLK(clk), .I_ARST_N(arst_n),
      .I_LOAD_START(load_start), .I_LOAD_STOP(load_stop), .I_DATA(data), .O_PORT(port), .O_MOTOR_ON(motor_on),
      .O_BUSY(busy), .O_BIT_VALID(bit_valid), .O_BIT(o_bit), .O_WORD_VALID(word_valid), .O_WORD(word));
   cipl_latch_model cipl_latch_model_i (.i_clk(clk), .i_pins(port), .i_tape_det_n(tape_det_n), .o_data(data));
   initial
   begin
      forever #4 clk = ~clk;
   end
   // ==========
   // Tasks
   function automatic logic bit_of(input logic [7:0] w, input int i);
      return w[7-i];
   endfunction
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic finish_test();
      if (errors == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic pulse();
      tape_det_n <= 1'b0;
      repeat (3) @(posedge clk);
      tape_det_n <= 1'b1;
   endtask
   // Start pulse, then a mid-bit pulse only for a one
   task automatic tape_bit(input logic b);
      bits_q.push_back(b);
      pulse();
      repeat (MID_CYC - 3) @(posedge clk);
      if (b)
         pulse();
      else
         repeat (3) @(posedge clk);
      repeat (BIT_CYC - MID_CYC - 3) @(posedge clk);
   endtask
   // Bit and word monitor with the hang limit
   always @(posedge clk)
   begin
      cycles++;
      if (bit_valid === 1'b1)
      begin
         check("bit pending", {7'h00, bits_q.size() != 0}, 8'h01);
         check("bit", {7'h00, o_bit}, {7'h00, bits_q.pop_front()});
      end
      if (word_valid === 1'b1)
         check("word", word, words_q.pop_front());
      if (cycles == 10000)
      begin
         errors++;
         finish_test();
      end
   end
   // ==========
   // Main sequence
   initial
   begin
      logic [7:0] w [5];
      w = '{8'h00, 8'hff, 8'ha5, 8'h00, 8'h00};
      void'($urandom(32'h6f5c5332));
      w[3] = 8'($urandom);
      w[4] = 8'($urandom);
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk);
      load_start <= 1'b1;
      @(posedge clk);
      load_start <= 1'b0;
      // Quiet tape: polling reads alone must not yield bits
      repeat (200) @(posedge clk);
      check("motor", {7'h00, motor_on}, 8'h01);
      foreach (w[k])
      begin
         words_q.push_back(w[k]);
         for (int i = 0; i < 8; i++)
            tape_bit(bit_of(w[k], i));
      end
      load_stop <= 1'b1;
      for (int t = 0; t < 500 && busy !== 1'b0; t++)
         @(posedge clk);
      load_stop <= 1'b0;
      check("busy", {7'h00, busy}, 8'h00);
      check("motor", {7'h00, motor_on}, 8'h00);
      check("left", 8'(bits_q.size() + words_q.size()), 8'h00);
      finish_test();
   end
endmodule
